// ---- verilog/efg_error_fault_gating.sv ----
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
// Contract
// - escalation off blocks direct fault machine check
// - mapping error reported only when enabled
// - l2 multibit detected only when not disabled
// - l2 multibit interrupt only when enabled
// - mem multibit irq: ecc on, disables zero
// - pci irq: detect clear and enable set
// - lbus parity irq: check clear, enable set
module efg_error_fault_gating (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic srst_i,
	// avalon-mm slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// raw error pins from platform units
	input wire logic map_err_i,
	input wire logic l2_multibit_err_i,
	input wire logic mem_multibit_err_i,
	input wire logic pci_parity_err_i,
	input wire logic pci_master_abort_i,
	input wire logic lbus_parity_err_i,
	// toward the core
	output logic core_fault_o,
	output logic core_mcheck_o,
	output logic err_irq_o
);
	import efg_pkg::*;

	logic [EFG_NSRC-1:0] raw_s1_q;
	logic [EFG_NSRC-1:0] raw_s2_q;
	logic [EFG_NSRC-1:0] raw_prev_q;
	logic [EFG_NSRC-1:0] gated_d;
	logic [EFG_NSRC-1:0] status_q;
	logic [EFG_NSRC-1:0] mask_q;
	logic [EFG_NSRC-1:0] rise;
	logic fault_escalate_en_q;
	logic map_err_en_q;
	logic l2_multibit_detect_dis_q;
	logic l2_multibit_irq_en_q;
	logic [2:0] mem_cfg_q;
	logic [1:0] pci_detect_disable_q;
	logic [1:0] pci_enable_q;
	logic lbus_parity_check_dis_q;
	logic lbus_parity_irq_en_q;
	logic ack_q;
	logic wr_go;
	logic rd_go;

	// pins cross in from other units' timing, two stages first
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			raw_s1_q <= '0;
			raw_s2_q <= '0;
			raw_prev_q <= '0;
		end else begin
			raw_s1_q <= {lbus_parity_err_i, pci_master_abort_i, pci_parity_err_i,
				mem_multibit_err_i, l2_multibit_err_i, map_err_i};
			raw_s2_q <= raw_s1_q;
			raw_prev_q <= raw_s2_q;
		end
	end

	assign rise = raw_s2_q & ~raw_prev_q;

	// one wait state: ack registered, so waitrequest drops on second cycle
	assign wr_go = avs_write_i & ack_q;
	assign rd_go = avs_read_i & ack_q;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ack_q <= 1'b0;
			avs_waitrequest_o <= 1'b1;
		end else begin
			// ack pulses for one cycle per request
			ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
			avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~ack_q);
		end
	end

	// detection gating per source
	always_comb begin
		gated_d = '0;
		gated_d[EFG_SRC_MAP] = rise[EFG_SRC_MAP] & map_err_en_q;
		gated_d[EFG_SRC_L2] = rise[EFG_SRC_L2] & ~l2_multibit_detect_dis_q;
		gated_d[EFG_SRC_MEM] = rise[EFG_SRC_MEM] & mem_cfg_q[EFG_MEM_ECC_EN_BIT]
			& ~mem_cfg_q[EFG_MEM_MB_DIS_BIT];
		gated_d[EFG_SRC_PCI_PAR] = rise[EFG_SRC_PCI_PAR]
			& ~pci_detect_disable_q[EFG_PCI_PAR_BIT];
		gated_d[EFG_SRC_PCI_MAB] = rise[EFG_SRC_PCI_MAB]
			& ~pci_detect_disable_q[EFG_PCI_MABORT_BIT];
		gated_d[EFG_SRC_LBUS] = rise[EFG_SRC_LBUS] & ~lbus_parity_check_dis_q;
	end

	// interrupt-enable per source, gathered from the control registers into mask_q
	always_comb begin
		mask_q = '0;
		mask_q[EFG_SRC_MAP] = map_err_en_q;
		mask_q[EFG_SRC_L2] = l2_multibit_irq_en_q;
		mask_q[EFG_SRC_MEM] = ~mem_cfg_q[EFG_MEM_MB_IRQ_BIT];
		mask_q[EFG_SRC_PCI_PAR] = pci_enable_q[EFG_PCI_PAR_BIT];
		mask_q[EFG_SRC_PCI_MAB] = pci_enable_q[EFG_PCI_MABORT_BIT];
		mask_q[EFG_SRC_LBUS] = lbus_parity_irq_en_q;
	end

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			status_q <= '0;
		end else if (wr_go && avs_address_i == EFG_OFF_STATUS) begin
			status_q <= (status_q & ~avs_writedata_i[EFG_NSRC-1:0]) | gated_d;
		end else begin
			status_q <= status_q | gated_d;
		end
	end

	// control registers
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			fault_escalate_en_q <= EFG_RST_ZERO[0];
			map_err_en_q <= EFG_RST_ZERO[0];
			l2_multibit_detect_dis_q <= EFG_RST_ZERO[0];
			l2_multibit_irq_en_q <= EFG_RST_ZERO[0];
			mem_cfg_q <= EFG_RST_ZERO[2:0];
			pci_detect_disable_q <= EFG_RST_ZERO[1:0];
			pci_enable_q <= EFG_RST_ZERO[1:0];
			lbus_parity_check_dis_q <= EFG_RST_ZERO[0];
			lbus_parity_irq_en_q <= EFG_RST_ZERO[0];
		end else if (wr_go) begin
			if (avs_address_i == EFG_OFF_CORE_CTRL) begin
				fault_escalate_en_q <= avs_writedata_i[0];
			end else if (avs_address_i == EFG_OFF_COH_EN) begin
				map_err_en_q <= avs_writedata_i[0];
			end else if (avs_address_i == EFG_OFF_L2_DIS) begin
				l2_multibit_detect_dis_q <= avs_writedata_i[0];
			end else if (avs_address_i == EFG_OFF_L2_IRQ) begin
				l2_multibit_irq_en_q <= avs_writedata_i[0];
			end else if (avs_address_i == EFG_OFF_MEM_CFG) begin
				mem_cfg_q <= avs_writedata_i[2:0];
			end else if (avs_address_i == EFG_OFF_PCI_DIS) begin
				pci_detect_disable_q <= avs_writedata_i[1:0];
			end else if (avs_address_i == EFG_OFF_PCI_EN) begin
				pci_enable_q <= avs_writedata_i[1:0];
			end else if (avs_address_i == EFG_OFF_LBUS_DIS) begin
				lbus_parity_check_dis_q <= avs_writedata_i[0];
			end else if (avs_address_i == EFG_OFF_LBUS_IRQ) begin
				lbus_parity_irq_en_q <= avs_writedata_i[0];
			end
		end
	end

	// read mux
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			avs_readdata_o <= EFG_RST_ZERO;
		end else if ((avs_read_i | avs_write_i) && !ack_q) begin
			avs_readdata_o <= EFG_RST_ZERO;
			if (avs_address_i == EFG_OFF_CORE_CTRL) begin
				avs_readdata_o[0] <= fault_escalate_en_q;
			end else if (avs_address_i == EFG_OFF_COH_EN) begin
				avs_readdata_o[0] <= map_err_en_q;
			end else if (avs_address_i == EFG_OFF_L2_DIS) begin
				avs_readdata_o[0] <= l2_multibit_detect_dis_q;
			end else if (avs_address_i == EFG_OFF_L2_IRQ) begin
				avs_readdata_o[0] <= l2_multibit_irq_en_q;
			end else if (avs_address_i == EFG_OFF_MEM_CFG) begin
				avs_readdata_o[2:0] <= mem_cfg_q;
			end else if (avs_address_i == EFG_OFF_PCI_DIS) begin
				avs_readdata_o[1:0] <= pci_detect_disable_q;
			end else if (avs_address_i == EFG_OFF_PCI_EN) begin
				avs_readdata_o[1:0] <= pci_enable_q;
			end else if (avs_address_i == EFG_OFF_LBUS_DIS) begin
				avs_readdata_o[0] <= lbus_parity_check_dis_q;
			end else if (avs_address_i == EFG_OFF_LBUS_IRQ) begin
				avs_readdata_o[0] <= lbus_parity_irq_en_q;
			end else if (avs_address_i == EFG_OFF_STATUS) begin
				avs_readdata_o[EFG_NSRC-1:0] <= status_q;
			end else if (avs_address_i == EFG_OFF_MASK) begin
				avs_readdata_o[EFG_NSRC-1:0] <= mask_q;
			end else if (avs_address_i == EFG_OFF_RAW) begin
				avs_readdata_o[EFG_NSRC-1:0] <= raw_s2_q;
			end
		end
	end

	// outputs toward the core
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			err_irq_o <= 1'b0;
			core_fault_o <= 1'b0;
			core_mcheck_o <= 1'b0;
		end else begin
			err_irq_o <= |(status_q & mask_q);
			core_fault_o <= |status_q;
			// without escalation, faults reach the core only through core_fault_o and the interrupt
			core_mcheck_o <= fault_escalate_en_q & (|status_q);
		end
	end

endmodule : efg_error_fault_gating

// ---- verilog/efg_pkg.sv ----
package efg_pkg;
	// register word offsets
	localparam logic [3:0] EFG_OFF_CORE_CTRL = 4'h0;
	localparam logic [3:0] EFG_OFF_COH_EN = 4'h1;
	localparam logic [3:0] EFG_OFF_L2_DIS = 4'h2;
	localparam logic [3:0] EFG_OFF_L2_IRQ = 4'h3;
	localparam logic [3:0] EFG_OFF_MEM_CFG = 4'h4;
	localparam logic [3:0] EFG_OFF_PCI_DIS = 4'h5;
	localparam logic [3:0] EFG_OFF_PCI_EN = 4'h6;
	localparam logic [3:0] EFG_OFF_LBUS_DIS = 4'h7;
	localparam logic [3:0] EFG_OFF_LBUS_IRQ = 4'h8;
	localparam logic [3:0] EFG_OFF_STATUS = 4'h9;
	localparam logic [3:0] EFG_OFF_MASK = 4'hA;
	localparam logic [3:0] EFG_OFF_RAW = 4'hB;
	// memory config field positions
	localparam int EFG_MEM_ECC_EN_BIT = 0;
	localparam int EFG_MEM_MB_DIS_BIT = 1;
	localparam int EFG_MEM_MB_IRQ_BIT = 2;
	// pci fields: bit0 parity, bit1 master abort
	localparam int EFG_PCI_PAR_BIT = 0;
	localparam int EFG_PCI_MABORT_BIT = 1;
	// status bit positions
	localparam int EFG_SRC_MAP = 0;
	localparam int EFG_SRC_L2 = 1;
	localparam int EFG_SRC_MEM = 2;
	localparam int EFG_SRC_PCI_PAR = 3;
	localparam int EFG_SRC_PCI_MAB = 4;
	localparam int EFG_SRC_LBUS = 5;
	localparam int EFG_NSRC = 6;
	// reset values and other word constants
	localparam logic [31:0] EFG_RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] EFG_RST_DIS_ALL = 32'h0000_0003;
	localparam logic [31:0] EFG_UNMAPPED = 32'hDEAD_0000;
	localparam logic [31:0] EFG_ID_VALUE = 32'h1234_0000;
endpackage : efg_pkg

// ---- tb/efg_checker.sv ----
`timescale 1ns/10ps
module efg_checker (
	// clock, reset and register bus
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic avs_waitrequest_o,
	// error pins and core side
	input wire logic map_err_i,
	input wire logic l2_multibit_err_i,
	input wire logic mem_multibit_err_i,
	input wire logic pci_parity_err_i,
	input wire logic pci_master_abort_i,
	input wire logic lbus_parity_err_i,
	input wire logic core_fault_o,
	input wire logic core_mcheck_o,
	input wire logic err_irq_o
);
	// shadow of the control words, taken at the accepting edge
	logic [2:0] ctl_q [0:8];
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ctl_q <= '{default: 3'h0};
		end else if (avs_write_i && !avs_waitrequest_o && avs_address_i < 4'h9) begin
			ctl_q[avs_address_i] <= avs_writedata_i[2:0];
		end
	end
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);
	wait_one_a: assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
		else $error("bus answer late");
	esc_gate_a: assert property (!ctl_q[0][0] && !$past(ctl_q[0][0]) |-> !core_mcheck_o)
		else $error("machine check without escalation");
	map_irq_a: assert property ($rose(map_err_i) && ctl_q[1][0] |-> ##4 err_irq_o)
		else $error("map error not reported");
	l2_irq_a: assert property ($rose(l2_multibit_err_i) && !ctl_q[2][0] && ctl_q[3][0]
		|-> ##4 err_irq_o) else $error("l2 error not reported");
	mem_irq_a: assert property ($rose(mem_multibit_err_i) && ctl_q[4] == 3'h1
		|-> ##4 err_irq_o) else $error("mem error not reported");
	pci_irq_a: assert property ($rose(pci_parity_err_i) && !ctl_q[5][0] && ctl_q[6][0]
		|-> ##4 err_irq_o) else $error("pci error not reported");
	mab_irq_a: assert property ($rose(pci_master_abort_i) && !ctl_q[5][1] && ctl_q[6][1]
		|-> ##4 err_irq_o) else $error("pci abort not reported");
	lbus_irq_a: assert property ($rose(lbus_parity_err_i) && !ctl_q[7][0] && ctl_q[8][0]
		|-> ##4 err_irq_o) else $error("lbus error not reported");
	irq_src_a: assert property (err_irq_o |-> core_fault_o)
		else $error("irq without status");
endmodule : efg_checker
bind efg_error_fault_gating efg_checker i_chk (.*);

// ---- tb/efg_core_model.sv ----
`timescale 1ns/10ps
module efg_core_model (
	// clock, reset, core input and taken output
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic mcheck_i,
	output logic mc_taken_o
);
	// fault alone never enters machine check, only the escalated line
	always_ff @(posedge core_clk_i) begin
		mc_taken_o <= !srst_i && (mc_taken_o || mcheck_i);
	end
endmodule : efg_core_model

// ---- tb/efg_error_fault_gating_test.sv ----
`timescale 1ns/10ps
module efg_error_fault_gating_test;
	typedef struct packed {logic [3:0] a; logic [3:0] b; logic [2:0] d; logic [2:0] p;
		logic irq; logic [6:0] st;} efg_row_t;
	// st of 7'h7F: status left open where detect gating is unspecified
	efg_row_t rows [15] = '{'{4'h1, 4'h1, 3'h0, 3'h0, 1'h0, 7'h00},
		'{4'h1, 4'h1, 3'h1, 3'h0, 1'h1, 7'h01}, '{4'h2, 4'h3, 3'h1, 3'h1, 1'h0, 7'h00},
		'{4'h3, 4'h3, 3'h1, 3'h1, 1'h1, 7'h02}, '{4'h2, 4'h2, 3'h0, 3'h1, 1'h0, 7'h02},
		'{4'h4, 4'h4, 3'h1, 3'h2, 1'h1, 7'h04}, '{4'h4, 4'h4, 3'h3, 3'h2, 1'h0, 7'h7F},
		'{4'h4, 4'h4, 3'h5, 3'h2, 1'h0, 7'h7F}, '{4'h4, 4'h4, 3'h0, 3'h2, 1'h0, 7'h7F},
		'{4'h6, 4'h6, 3'h1, 3'h3, 1'h1, 7'h08}, '{4'h5, 4'h6, 3'h1, 3'h3, 1'h0, 7'h00},
		'{4'h6, 4'h6, 3'h2, 3'h4, 1'h1, 7'h10}, '{4'h6, 4'h6, 3'h1, 3'h4, 1'h0, 7'h10},
		'{4'h7, 4'h8, 3'h1, 3'h5, 1'h0, 7'h00}, '{4'h8, 4'h8, 3'h1, 3'h5, 1'h1, 7'h20}};
	int num_errors = 0;
	int cmp_count = 0;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [5:0] err_q = 6'h00;
	logic [31:0] avs_readdata_o, rd_q;
	logic avs_waitrequest_o, core_fault_o, core_mcheck_o, err_irq_o, mc_taken;
	efg_error_fault_gating i_dut (.*, .map_err_i(err_q[0]), .l2_multibit_err_i(err_q[1]),
		.mem_multibit_err_i(err_q[2]), .pci_parity_err_i(err_q[3]),
		.pci_master_abort_i(err_q[4]), .lbus_parity_err_i(err_q[5]));
	efg_core_model i_core (.core_clk_i(core_clk_i), .srst_i(srst_i), .mcheck_i(core_mcheck_o),
		.mc_taken_o(mc_taken));
	always #5 core_clk_i = ~core_clk_i;
	task wrap_up;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task chk_word(input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask : chk_word
	task chk_bit(input logic exp, input logic got);
		chk_word({31'h0, exp}, {31'h0, got});
	endtask : chk_bit
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		// the rising edge that sees waitrequest low completes the transfer
		do begin
			@(posedge core_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		if (avs_waitrequest_o !== 1'b0) begin
			num_errors++;
			wrap_up();
		end
		rd_q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus
	task rst;
		srst_i <= 1'b1;
		repeat (6) @(posedge core_clk_i);
		srst_i <= 1'b0;
	endtask : rst
	task fire(input int p);
		@(posedge core_clk_i);
		err_q[p] <= 1'b1;
		repeat (3) @(posedge core_clk_i);
		err_q[p] <= 1'b0;
		repeat (6) @(posedge core_clk_i);
		@(negedge core_clk_i);
	endtask : fire
	initial begin
		foreach (rows[i]) begin
			rst();
			bus(1'b1, rows[i].a, {29'h0, rows[i].d});
			bus(1'b1, rows[i].b, {29'h0, rows[i].d});
			fire(rows[i].p);
			chk_bit(rows[i].irq, err_irq_o);
			chk_bit(1'b0, core_mcheck_o);
			if (rows[i].st != 7'h7F) chk_bit(|rows[i].st, core_fault_o);
			bus(1'b0, 4'h9, 32'h0000_0000);
			if (rows[i].st != 7'h7F) chk_word({25'h0, rows[i].st}, rd_q);
		end
		rst();
		bus(1'b1, 4'hC, 32'hFFFF_FFFF);
		bus(1'b0, 4'hC, 32'h0000_0000);
		chk_word(32'h0000_0000, rd_q);
		bus(1'b0, 4'h0, 32'h0000_0000);
		chk_word(32'h0000_0000, rd_q);
		bus(1'b1, 4'h0, 32'h0000_0001);
		bus(1'b1, 4'h1, 32'h0000_0001);
		fire(0);
		chk_bit(1'b1, core_mcheck_o);
		chk_bit(1'b1, mc_taken);
		bus(1'b1, 4'h9, 32'h0000_0001);
		repeat (2) @(negedge core_clk_i);
		chk_bit(1'b0, err_irq_o);
		chk_bit(1'b0, core_fault_o);
		chk_bit(1'b0, core_mcheck_o);
		wrap_up();
	end
	initial begin
		repeat (5000) @(posedge core_clk_i);
		num_errors++;
		wrap_up();
	end
endmodule : efg_error_fault_gating_test
